//--- src/pllc_pkg.sv
`default_nettype none
package pllc_pkg;
  // Register byte addresses
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] ADDR_DIV = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_INT_STAT = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 5'h0C;
  localparam logic [ADDR_W-1:0] ADDR_REF_PER = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_OSC_HALF = 5'h14;

  // Divider register: one field per generated clock, ratio = 2 * (field + 1) oscillator periods
  localparam int NUM_OUT = 3;
  localparam int EXT_IDX = 2;
  localparam int DIV_W = 4;
  localparam int DIV_REG_W = NUM_OUT * DIV_W;
  localparam logic [DIV_REG_W-1:0] DIV_RESET = 12'h000;

  // Status register bits
  localparam int STAT_LOCK = 0;
  localparam int STAT_EN = 1;
  localparam int STAT_RST = 2;
  localparam int STAT_DET = 3;
  localparam int STAT_REF_LOST = 4;

  // Interrupt bits, shared by status and mask
  localparam int INT_W = 3;
  localparam int INT_LOCK_GAIN = 0;
  localparam int INT_LOCK_LOSS = 1;
  localparam int INT_REF_LOSS = 2;
  localparam logic [INT_W-1:0] INT_MASK_RESET = 3'h0;

  // Responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing
  localparam int CLK_FREQ_MHZ = 10;
  localparam int REF_LOSS_TIME_US = 100;
  localparam int REF_LOSS_CYCLES = REF_LOSS_TIME_US * CLK_FREQ_MHZ;
  localparam int LOCK_MATCHES_DEF = 8;
  localparam int OSC_HALF_INIT_DEF = 8;
  localparam int PER_W_DEF = 16;

  typedef enum logic [1:0] {ST_OFF, ST_WAIT_REF, ST_RUN} pllc_state_type;

  function automatic logic pllc_mapped(input logic [ADDR_W-1:0] a);
    return (a == ADDR_DIV) || (a == ADDR_STATUS) || (a == ADDR_INT_STAT) ||
           (a == ADDR_INT_MASK) || (a == ADDR_REF_PER) || (a == ADDR_OSC_HALF);
  endfunction : pllc_mapped
endpackage : pllc_pkg
`default_nettype wire

//--- src/pllc_reg_if.sv
`default_nettype none
interface pllc_reg_if;
  import pllc_pkg::*;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;
  modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, input wr_hit, rd_data, rd_hit);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, output wr_hit, rd_data, rd_hit);
endinterface : pllc_reg_if
`default_nettype wire

//--- src/pllc_axil.sv
`default_nettype none
module pllc_axil (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register side
  pllc_reg_if.slave rb
);
  import pllc_pkg::*;

  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_wr;
  logic ar_take;
  logic upper_ok_w;
  logic upper_ok_r;

  // Address and data are held until both are in; the response follows both
  assign do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign upper_ok_w = (awaddr_q[31:ADDR_W] == '0);
  assign upper_ok_r = (s_axi_araddr[31:ADDR_W] == '0);
  assign rb.wr_en = do_wr && upper_ok_w;
  assign rb.wr_addr = awaddr_q[ADDR_W-1:0];
  assign rb.wr_data = wdata_q;
  assign rb.wr_strb = wstrb_q;
  assign rb.rd_en = ar_take && upper_ok_r;
  assign rb.rd_addr = s_axi_araddr[ADDR_W-1:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awaddr_q <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (upper_ok_w && rb.wr_hit) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read data is captured at the address handshake, so read side effects happen once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= (upper_ok_r && rb.rd_hit) ? rb.rd_data : 32'h00000000;
      s_axi_rresp <= (upper_ok_r && rb.rd_hit) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : pllc_axil
`default_nettype wire

//--- src/pllc_lock_det.sv
`default_nettype none
module pllc_lock_det #(
  parameter int MATCHES = pllc_pkg::LOCK_MATCHES_DEF
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Comparison results
  input wire logic clear,
  input wire logic cmp_valid,
  input wire logic cmp_match,
  // Lock
  output logic locked_q
);
  import pllc_pkg::*;

  localparam int CW = $clog2(MATCHES + 1);
  localparam logic [CW-1:0] TARGET = CW'(MATCHES);
  localparam logic [CW-1:0] ONE = CW'(1);

  if (MATCHES < 1) begin : g_bad_matches
    $error("pllc_lock_det: MATCHES must be at least 1");
  end

  logic [CW-1:0] streak_q;

  // A single mismatch drops lock, so the flag may toggle during acquisition
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      streak_q <= '0;
      locked_q <= 1'b0;
    end else if (cmp_valid) begin
      if (!cmp_match) begin
        streak_q <= '0;
        locked_q <= 1'b0;
      end else begin
        if (streak_q != TARGET)
          streak_q <= streak_q + ONE;
        locked_q <= (streak_q >= TARGET - ONE);
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  lock_rise_cause_a: assert property ($rose(locked_q) |-> $past(cmp_valid && cmp_match && !clear))
    else $error("lock rose without a matching comparison");
  mismatch_drop_a: assert property ((cmp_valid && !cmp_match) |=> !locked_q)
    else $error("lock held after a mismatch");
endmodule : pllc_lock_det
`default_nettype wire

//--- src/pllc_top.sv
`default_nettype none
module pllc_top #(
  parameter int PER_W = pllc_pkg::PER_W_DEF,
  parameter int LOCK_MATCHES = pllc_pkg::LOCK_MATCHES_DEF,
  parameter int OSC_HALF_INIT = pllc_pkg::OSC_HALF_INIT_DEF,
  parameter int REF_LOSS_CYCLES = pllc_pkg::REF_LOSS_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Generator controls
  input wire logic gen_enable,
  input wire logic gen_reset,
  input wire logic det_enable,
  input wire logic ref_clk_in,
  // Generated clocks
  output logic [1:0] int_clk_q,
  output logic ext_clk_p_q,
  output logic ext_clk_n_q,
  // Status
  output logic locked_q,
  output logic pfd_up_q,
  output logic pfd_dn_q,
  output logic irq_q
);
  import pllc_pkg::*;

  localparam logic [PER_W-1:0] HALF_INIT = PER_W'(OSC_HALF_INIT);
  localparam logic [PER_W-1:0] LOSS_CNT = PER_W'(REF_LOSS_CYCLES);
  localparam logic [PER_W-1:0] P_ONE = PER_W'(1);
  localparam logic [PER_W:0] W_ONE = (PER_W + 1)'(1);
  localparam logic [DIV_W-1:0] D_ONE = DIV_W'(1);

  if (PER_W < 8 || PER_W > 31 || OSC_HALF_INIT < 1 || OSC_HALF_INIT >= (1 << PER_W) ||
      REF_LOSS_CYCLES < 2 || REF_LOSS_CYCLES >= (1 << PER_W)) begin : g_bad_params
    $error("pllc_top: parameter values out of range");
  end

  pllc_reg_if rb ();

  pllc_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rb(rb)
  );

  // Control decode
  logic hold_off;
  logic run_ok;
  logic run_next;
  logic ref_d_q;
  logic ref_rise;
  pllc_state_type st_q;

  // Either control forces the instance off; both are levels sampled on aclk
  assign hold_off = !gen_enable || gen_reset;
  assign run_ok = (st_q == ST_RUN) && !hold_off;
  assign run_next = aresetn && run_ok;
  assign ref_rise = ref_clk_in && !ref_d_q;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      ref_d_q <= 1'b0;
    else
      ref_d_q <= ref_clk_in;
  end

  // Acquisition sequence
  always_ff @(posedge aclk) begin
    if (!aresetn || hold_off) begin
      st_q <= ST_OFF;
    end else begin
      case (st_q)
        ST_OFF: st_q <= ST_WAIT_REF;
        ST_WAIT_REF: begin
          if (ref_rise)
            st_q <= ST_RUN;
        end
        ST_RUN: st_q <= ST_RUN;
        default: st_q <= ST_OFF;
      endcase
    end
  end

  // Reference period measurement
  logic [PER_W-1:0] ref_cnt_q;
  logic [PER_W-1:0] ref_per_q;
  logic ref_lost_q;
  logic ref_lost_set;
  logic cmp;

  // The counter saturates so a stopped reference cannot wrap into a false period
  always_ff @(posedge aclk) begin
    if (!aresetn || st_q == ST_OFF)
      ref_cnt_q <= '0;
    else if (ref_rise)
      ref_cnt_q <= P_ONE;
    else if (ref_cnt_q != LOSS_CNT)
      ref_cnt_q <= ref_cnt_q + P_ONE;
  end

  assign cmp = ref_rise && run_ok && (ref_cnt_q != LOSS_CNT);
  assign ref_lost_set = run_ok && !ref_rise && !ref_lost_q && (ref_cnt_q == LOSS_CNT);

  always_ff @(posedge aclk) begin
    if (!aresetn)
      ref_per_q <= '0;
    else if (cmp)
      ref_per_q <= ref_cnt_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run_ok || ref_rise)
      ref_lost_q <= 1'b0;
    else if (ref_lost_set)
      ref_lost_q <= 1'b1;
  end

  // Frequency comparison against the oscillator period
  logic [PER_W-1:0] half_q;
  logic [PER_W-1:0] phase_q;
  logic osc_q;
  logic [PER_W:0] osc_per;
  logic [PER_W:0] meas;
  logic too_slow;
  logic too_fast;
  logic match;
  logic pfd_up;
  logic pfd_dn;

  assign osc_per = {half_q, 1'b0};
  assign meas = {1'b0, ref_cnt_q};
  // A one-cycle window absorbs odd reference periods that an even period cannot hit
  assign too_slow = osc_per > (meas + W_ONE);
  assign too_fast = (osc_per + W_ONE) < meas;
  assign match = !too_slow && !too_fast;
  assign pfd_up = cmp && det_enable && too_slow;
  assign pfd_dn = cmp && det_enable && too_fast;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pfd_up_q <= 1'b0;
      pfd_dn_q <= 1'b0;
    end else begin
      pfd_up_q <= pfd_up;
      pfd_dn_q <= pfd_dn;
    end
  end

  // Oscillator; it free-runs on its last setting while corrections are gated
  logic osc_wrap;
  logic osc_rise;

  assign osc_wrap = run_ok && (phase_q >= half_q - P_ONE);
  assign osc_rise = osc_wrap && !osc_q;

  always_ff @(posedge aclk) begin
    if (!aresetn || hold_off)
      half_q <= HALF_INIT;
    else if (pfd_up && half_q != P_ONE)
      half_q <= half_q - P_ONE;
    else if (pfd_dn && half_q != '1)
      half_q <= half_q + P_ONE;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || hold_off) begin
      phase_q <= '0;
      osc_q <= 1'b0;
    end else if (st_q == ST_WAIT_REF) begin
      phase_q <= '0;
      osc_q <= ref_rise;
    end else if (st_q == ST_RUN) begin
      if (osc_wrap) begin
        phase_q <= '0;
        osc_q <= !osc_q;
      end else begin
        phase_q <= phase_q + P_ONE;
      end
    end else begin
      phase_q <= '0;
      osc_q <= 1'b0;
    end
  end

  // Output dividers and registers
  logic [DIV_REG_W-1:0] div_q;
  logic [NUM_OUT-1:0] clk_d;
  logic [NUM_OUT-1:0] clk_q;

  for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] ratio;
    assign ratio = div_q[i*DIV_W +: DIV_W];
    always_ff @(posedge aclk) begin
      if (!run_next)
        cnt_q <= '0;
      else if (osc_rise)
        cnt_q <= (cnt_q >= ratio) ? '0 : cnt_q + D_ONE;
    end
    assign clk_d[i] = (osc_rise && cnt_q >= ratio) ? !clk_q[i] : clk_q[i];
    always_ff @(posedge aclk) begin
      clk_q[i] <= run_next && clk_d[i];
    end
  end

  assign int_clk_q = clk_q[1:0];
  assign ext_clk_p_q = clk_q[EXT_IDX];

  always_ff @(posedge aclk) begin
    ext_clk_n_q <= run_next && !clk_d[EXT_IDX];
  end

  // Lock detection; frozen while corrections are gated
  logic lock_clear;
  assign lock_clear = !run_ok || (ref_lost_q && det_enable);

  pllc_lock_det #(
    .MATCHES(LOCK_MATCHES)
  ) u_lock (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(lock_clear),
    .cmp_valid(cmp && det_enable),
    .cmp_match(match),
    .locked_q(locked_q)
  );

  // Interrupts
  logic lock_prev_q;
  logic [INT_W-1:0] events;
  logic [INT_W-1:0] int_stat_q;
  logic [INT_W-1:0] int_stat_d;
  logic [INT_W-1:0] int_mask_q;
  logic rd_clear;

  always_ff @(posedge aclk) begin
    if (!aresetn)
      lock_prev_q <= 1'b0;
    else
      lock_prev_q <= locked_q;
  end

  always_comb begin
    events = '0;
    events[INT_LOCK_GAIN] = locked_q && !lock_prev_q;
    events[INT_LOCK_LOSS] = !locked_q && lock_prev_q;
    events[INT_REF_LOSS] = ref_lost_set;
  end

  // A new event in the clearing cycle survives the read
  assign rd_clear = rb.rd_en && (rb.rd_addr == ADDR_INT_STAT);
  assign int_stat_d = events | (int_stat_q & ~{INT_W{rd_clear}});

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_stat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      int_stat_q <= int_stat_d;
      irq_q <= |(int_stat_d & int_mask_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= DIV_RESET;
      int_mask_q <= INT_MASK_RESET;
    end else if (rb.wr_en) begin
      if (rb.wr_addr == ADDR_DIV && rb.wr_strb[0])
        div_q[7:0] <= rb.wr_data[7:0];
      if (rb.wr_addr == ADDR_DIV && rb.wr_strb[1])
        div_q[DIV_REG_W-1:8] <= rb.wr_data[DIV_REG_W-1:8];
      if (rb.wr_addr == ADDR_INT_MASK && rb.wr_strb[0])
        int_mask_q <= rb.wr_data[INT_W-1:0];
    end
  end

  assign rb.wr_hit = pllc_mapped(rb.wr_addr);
  assign rb.rd_hit = pllc_mapped(rb.rd_addr);

  always_comb begin
    rb.rd_data = 32'h00000000;
    case (rb.rd_addr)
      ADDR_DIV: rb.rd_data[DIV_REG_W-1:0] = div_q;
      ADDR_STATUS: begin
        rb.rd_data[STAT_LOCK] = locked_q;
        rb.rd_data[STAT_EN] = gen_enable;
        rb.rd_data[STAT_RST] = gen_reset;
        rb.rd_data[STAT_DET] = det_enable;
        rb.rd_data[STAT_REF_LOST] = ref_lost_q;
      end
      ADDR_INT_STAT: rb.rd_data[INT_W-1:0] = int_stat_q;
      ADDR_INT_MASK: rb.rd_data[INT_W-1:0] = int_mask_q;
      ADDR_REF_PER: rb.rd_data[PER_W-1:0] = ref_per_q;
      ADDR_OSC_HALF: rb.rd_data[PER_W-1:0] = half_q;
      default: rb.rd_data = 32'h00000000;
    endcase
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_run2;
    run_next ##1 run_next;
  endsequence

  sequence s_resync;
    (st_q == ST_WAIT_REF) && ref_rise && !hold_off;
  endsequence

  off_clocks_zero_a: assert property (hold_off |=> (int_clk_q == 2'h0 && !ext_clk_p_q && !ext_clk_n_q))
    else $error("generated clock not zero while held off");
  off_lock_low_a: assert property (hold_off |=> !locked_q ##1 (!locked_q || !hold_off))
    else $error("lock high while held off");
  resync_start_a: assert property (s_resync |=> (st_q == ST_RUN && osc_q && phase_q == '0))
    else $error("oscillator not aligned to reference edge");
  reset_div_init_a: assert property (gen_reset |=> (half_q == HALF_INIT && phase_q == '0))
    else $error("divider counters not at initial values");
  pfd_gated_a: assert property ((!det_enable && !cmp) or !det_enable |=> (!pfd_up_q && !pfd_dn_q))
    else $error("correction passed with detector disabled");
  osc_alive_a: assert property (s_run2 |-> ($changed(phase_q) || $changed(osc_q)))
    else $error("oscillator stalled while running");
  ext_pair_a: assert property (run_next |=> (ext_clk_n_q != ext_clk_p_q))
    else $error("external pair not complementary");
  irq_level_a: assert property ((int_stat_q & int_mask_q) != '0 && !rd_clear |-> irq_q)
    else $error("interrupt low with unmasked status set");
endmodule : pllc_top
`default_nettype wire

//--- dv/pllc_fabric.sv
`default_nettype none
module pllc_fabric (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Scenario controls
  input wire logic [7:0] ref_half,
  input wire logic ref_run,
  input wire logic det_on,
  // Generator side
  output logic ref_clk_in,
  output logic det_enable,
  input wire logic locked_q,
  output logic lock_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ref_cnt_q;
  logic [7:0] idle_q;
  logic [7:0] held_q;
  // Stopped reference stands low, as a quiet dedicated clock pin would
  always_ff @(posedge aclk) begin
    if (!aresetn || !ref_run) begin
      ref_cnt_q <= 8'h00;
      ref_clk_in <= 1'b0;
    end else if (ref_cnt_q >= ref_half - 8'h01) begin
      ref_cnt_q <= 8'h00;
      ref_clk_in <= ~ref_clk_in;
    end else begin
      ref_cnt_q <= ref_cnt_q + 8'h01;
    end
  end
  // Untrusted reference: shut the detector before the loss timer fires
  always_ff @(posedge aclk) begin
    if (!aresetn || ref_run) begin
      idle_q <= 8'h00;
    end else if (idle_q != 8'hFF) begin
      idle_q <= idle_q + 8'h01;
    end
  end
  assign det_enable = det_on && (idle_q < 8'h10);
  // A single high level is not taken as final lock
  always_ff @(posedge aclk) begin
    if (!aresetn || !locked_q) begin
      held_q <= 8'h00;
    end else if (held_q != 8'h40) begin
      held_q <= held_q + 8'h01;
    end
  end
  assign lock_ok = (held_q == 8'h40);
endmodule : pllc_fabric
`default_nettype wire

//--- dv/pllc_top_test.sv
`default_nettype none
module pllc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import pllc_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, int_clk_q;
  logic gen_enable, gen_reset, det_enable, ref_clk_in, ext_clk_p_q, ext_clk_n_q;
  logic locked_q, pfd_up_q, pfd_dn_q, irq_q, ref_run, det_on, lock_ok;
  logic [7:0] ref_half;
  int num_errors, tests_run, cycles;

  // Short counts keep the run brief; reference period stays below the loss limit
  pllc_top #(.LOCK_MATCHES(2), .REF_LOSS_CYCLES(40)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .gen_enable(gen_enable), .gen_reset(gen_reset), .det_enable(det_enable), .ref_clk_in(ref_clk_in),
    .int_clk_q(int_clk_q), .ext_clk_p_q(ext_clk_p_q), .ext_clk_n_q(ext_clk_n_q), .locked_q(locked_q),
    .pfd_up_q(pfd_up_q), .pfd_dn_q(pfd_dn_q), .irq_q(irq_q));

  pllc_fabric fab_u (.aclk(aclk), .aresetn(aresetn), .ref_half(ref_half), .ref_run(ref_run),
    .det_on(det_on), .ref_clk_in(ref_clk_in), .det_enable(det_enable), .locked_q(locked_q), .lock_ok(lock_ok));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic end_sim();
    if (num_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Ready is registered, so the level seen at the falling edge holds at the next rising edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(negedge aclk);
      aw = aw || (s_axi_awvalid && s_axi_awready);
      w = w || (s_axi_wvalid && s_axi_wready);
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    check(32'(s_axi_bresp), 32'(er));
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    check(s_axi_rdata & m, ed);
    check(32'(s_axi_rresp), 32'(er));
    @(posedge aclk);
  endtask : rd

  task automatic wait_lock();
    int n;
    n = 0;
    while (lock_ok !== 1'b1 && n < 600) begin
      @(negedge aclk);
      n++;
    end
    check(32'(lock_ok), 32'h1);
    @(posedge aclk);
  endtask : wait_lock

  task automatic quiet();
    repeat (3) @(posedge aclk);
    repeat (20) begin
      @(negedge aclk);
      check(32'({int_clk_q, ext_clk_p_q, ext_clk_n_q, locked_q}), 32'h0);
    end
    @(posedge aclk);
  endtask : quiet

  task automatic watch(input int n, output int tog, output int up, output int dn);
    logic prev;
    prev = int_clk_q[0];
    tog = 0;
    up = 0;
    dn = 0;
    repeat (n) begin
      @(negedge aclk);
      tog += int'(int_clk_q[0] !== prev);
      prev = int_clk_q[0];
      up += int'(pfd_up_q === 1'b1);
      dn += int'(pfd_dn_q === 1'b1);
      check(32'(ext_clk_n_q), 32'(!ext_clk_p_q));
    end
    @(posedge aclk);
  endtask : watch

  task automatic t_regs();
    rd(32'(ADDR_DIV), 32'hFFFFFFFF, 32'(DIV_RESET), RESP_OKAY);
    rd(32'(ADDR_INT_MASK), 32'hFFFFFFFF, 32'(INT_MASK_RESET), RESP_OKAY);
    wr(32'(ADDR_DIV), 32'h00000321, RESP_OKAY);
    rd(32'(ADDR_DIV), 32'h00000FFF, 32'h00000321, RESP_OKAY);
    rd(32'h00000018, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
    wr(32'h00000018, 32'h1, RESP_SLVERR);
    wr(32'(ADDR_DIV), 32'h0, RESP_OKAY);
  endtask : t_regs

  task automatic t_lock();
    int t, u, d;
    wait_lock();
    rd(32'(ADDR_STATUS), 32'h3, 32'h3, RESP_OKAY);
    watch(60, t, u, d);
    check(32'(t > 0), 32'h1);
  endtask : t_lock

  task automatic t_enable();
    wr(32'(ADDR_INT_MASK), 32'(1 << INT_LOCK_LOSS), RESP_OKAY);
    rd(32'(ADDR_INT_STAT), 32'h0, 32'h0, RESP_OKAY);
    gen_enable <= 1'b0;
    quiet();
    check(32'(irq_q), 32'h1);
    rd(32'(ADDR_INT_STAT), 32'h2, 32'h2, RESP_OKAY);
    rd(32'(ADDR_INT_STAT), 32'h2, 32'h0, RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(32'(irq_q), 32'h0);
    gen_enable <= 1'b1;
    wait_lock();
  endtask : t_enable

  // Slower reference must bring slow-down corrections only
  task automatic t_pfd();
    int t, u, d;
    ref_half <= 8'h0A;
    watch(400, t, u, d);
    check(32'(d > 0), 32'h1);
    check(32'(u), 32'h0);
    rd(32'(ADDR_OSC_HALF), 32'hFF, 32'h0A, RESP_OKAY);
  endtask : t_pfd

  task automatic t_reset();
    det_on <= 1'b0;
    gen_reset <= 1'b1;
    quiet();
    rd(32'(ADDR_OSC_HALF), 32'hFF, 32'(OSC_HALF_INIT_DEF), RESP_OKAY);
    ref_half <= 8'h08;
    gen_reset <= 1'b0;
    det_on <= 1'b1;
    wait_lock();
  endtask : t_reset

  task automatic t_detoff();
    int t, u, d;
    ref_run <= 1'b0;
    repeat (40) @(posedge aclk);
    check(32'(det_enable), 32'h0);
    watch(100, t, u, d);
    check(32'(t > 0), 32'h1);
    check(32'(u + d), 32'h0);
    ref_run <= 1'b1;
  endtask : t_detoff

  initial begin
    num_errors = 0;
    tests_run = 0;
    cycles = 0;
    aresetn = 1'b0;
    gen_enable = 1'b1;
    gen_reset = 1'b0;
    det_on = 1'b1;
    ref_run = 1'b1;
    ref_half = 8'h08;
    s_axi_awaddr = 32'h0;
    s_axi_wdata = 32'h0;
    s_axi_araddr = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_lock();
    t_enable();
    t_pfd();
    t_reset();
    t_detoff();
    end_sim();
  end
endmodule : pllc_top_test
`default_nettype wire
